/* File: hdl/timer_irq_regs.svh */
// register offsets, field positions and reset values of the timer
// interrupt flag block; byte addresses on a 32-bit register bus
`ifndef TIMER_IRQ_REGS_SVH
`define TIMER_IRQ_REGS_SVH

// per-channel window: status word, then enable word
`define CH_STRIDE     8'h08
`define STATUS_OFF    8'h00
`define ENABLE_OFF    8'h04
// summary event register and its mask, after the five windows
`define SUMMARY_OFF   8'h28
`define MASK_OFF      8'h2C

// flag and enable field positions, same in both registers
`define FLD_A         0
`define FLD_B         1
`define FLD_WRAP      2

// both per-channel registers come up as all-ones reserved, fields 0
`define REG_RESET     8'hF8
`define RSVD_ONES     5'h1F

// counter wrap end points
`define COUNT_MAX     16'hFFFF
`define COUNT_MIN     16'h0000

`endif

/* File: hdl/timer_irq_pkg.sv */
// shared types of the timer interrupt flag block
// assumes the register bus is AXI4-Lite with 32-bit data
package timer_irq_pkg;

  // write and read answers on the register bus
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

  // one 16-bit count or general register value
  typedef logic [15:0] count_t;

  // flag or enable group: wrap, b, a
  typedef logic [2:0] field3_t;

endpackage : timer_irq_pkg

/* File: hdl/timer_chan_flags.sv */
// one timer channel: three event flags, their enables and requests
// assumes count, general registers and strobes come from logic on aclk
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_regs.svh"

module timer_chan_flags (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   standby,
  // counter side
  input  wire timer_irq_pkg::count_t  timer_count,
  input  wire timer_irq_pkg::count_t  general_reg_a,
  input  wire timer_irq_pkg::count_t  general_reg_b,
  input  wire logic                   count_step,
  input  wire logic                   cap_mode_a,
  input  wire logic                   cap_mode_b,
  input  wire logic                   cap_a,
  input  wire logic                   cap_b,
  input  wire logic                   dma_clear_a,
  // register access strobes
  input  wire logic                   rd_status,
  input  wire logic                   wr_status,
  input  wire logic                   wr_enable,
  input  wire timer_irq_pkg::field3_t wdata,
  // register views, requests, event pulses
  output logic [7:0]                  status_q,
  output logic [7:0]                  enable_q,
  output timer_irq_pkg::field3_t      irq_q,
  output timer_irq_pkg::field3_t      set_q
);

  timer_irq_pkg::field3_t flag_r, flag_nxt;   // wrap, b, a flags
  timer_irq_pkg::field3_t en_r, en_nxt;       // their enables
  timer_irq_pkg::field3_t armed_r, armed_nxt; // seen as 1 by a read
  timer_irq_pkg::field3_t irq_r;              // requests
  timer_irq_pkg::field3_t clr_w;              // clear terms
  timer_irq_pkg::count_t  prev_r;             // count before last step
  logic                   init_w;             // reset or standby

  assign init_w = ~aresetn | standby;

  // compare only on a count update, so a parked equal count sets once
  assign set_q[`FLD_A] = cap_mode_a ? cap_a
    : count_step & (timer_count == general_reg_a);
  assign set_q[`FLD_B] = cap_mode_b ? cap_b
    : count_step & (timer_count == general_reg_b);
  // wrap either way across the end points
  assign set_q[`FLD_WRAP] = count_step &
    (((prev_r == `COUNT_MAX) & (timer_count == `COUNT_MIN)) |
     ((prev_r == `COUNT_MIN) & (timer_count == `COUNT_MAX)));

  // a zero written to an armed flag clears it; ones do nothing
  assign clr_w = ({3{wr_status}} & ~wdata & armed_r)
               | {2'b00, dma_clear_a};
  // set beats a clear in the same cycle
  assign flag_nxt  = set_q | (flag_r & ~clr_w);
  // arming lasts until the next status write or the flag drops
  assign armed_nxt = ((armed_r & ~{3{wr_status}}) |
                      ({3{rd_status}} & flag_r)) & flag_nxt;
  assign en_nxt    = wr_enable ? wdata : en_r;

  // flag state, cleared by reset and by standby
  always_ff @(posedge aclk) begin
    if (init_w) begin
      flag_r  <= 3'h0;
      armed_r <= 3'h0;
      en_r    <= 3'h0;
      irq_r   <= 3'h0;
      prev_r  <= 16'h0000;
    end else begin
      flag_r  <= flag_nxt;
      armed_r <= armed_nxt;
      en_r    <= en_nxt;
      irq_r   <= flag_nxt & en_nxt;
      prev_r  <= count_step ? timer_count : prev_r;
    end
  end

  // reserved upper bits ignore writes and read as ones
  assign status_q = {`RSVD_ONES, flag_r};
  assign enable_q = {`RSVD_ONES, en_r};
  assign irq_q    = irq_r;

  // read of a set flag b, then a zero write to it
  sequence s_read_b;
    rd_status && flag_r[`FLD_B];
  endsequence
  // zero write while armed; the read may lie many cycles back
  sequence s_zero_b;
    wr_status && armed_r[`FLD_B] && !wdata[`FLD_B] && !set_q[`FLD_B];
  endsequence

  // a read of a set flag b arms it for the next status write
  a_arm_b: assert property (@(posedge aclk)
    disable iff (init_w)
    s_read_b |=> armed_r[`FLD_B] || !flag_r[`FLD_B])
    else $error("flag b not armed by read");
  a_clear_b_seq: assert property (@(posedge aclk)
    disable iff (init_w)
    s_zero_b |=> !flag_r[`FLD_B])
    else $error("flag b not cleared by read then zero write");
  // standby also drops the flags, seen one cycle later as a fall
  a_clear_b_cause: assert property (@(posedge aclk)
    disable iff (init_w)
    $fell(flag_r[`FLD_B]) |->
    $past((wr_status && armed_r[`FLD_B]) || init_w))
    else $error("flag b dropped without armed zero write");
  a_cmp_b_set: assert property (@(posedge aclk) disable iff (init_w)
    !cap_mode_b && count_step && timer_count == general_reg_b
    |=> flag_r[`FLD_B]) else $error("flag b missed compare");
  a_cap_b_set: assert property (@(posedge aclk) disable iff (init_w)
    cap_mode_b && cap_b |=> flag_r[`FLD_B])
    else $error("flag b missed capture");
  a_clear_a_cause: assert property (@(posedge aclk) disable iff (init_w)
    $fell(flag_r[`FLD_A]) |->
    $past((wr_status && armed_r[`FLD_A]) || dma_clear_a || init_w))
    else $error("flag a dropped without cause");
  a_dma_clear: assert property (@(posedge aclk) disable iff (init_w)
    dma_clear_a && !set_q[`FLD_A] |=> !flag_r[`FLD_A])
    else $error("dma start did not clear flag a");
  a_cmp_a_set: assert property (@(posedge aclk) disable iff (init_w)
    !cap_mode_a && count_step && timer_count == general_reg_a
    |=> flag_r[`FLD_A]) else $error("flag a missed compare");
  a_cap_a_set: assert property (@(posedge aclk) disable iff (init_w)
    cap_mode_a && cap_a |=> flag_r[`FLD_A])
    else $error("flag a missed capture");
  a_init_value: assert property (@(posedge aclk)
    init_w |=> enable_q == `REG_RESET && status_q == `REG_RESET)
    else $error("registers not at reset value after init");
  a_wrap_set: assert property (@(posedge aclk) disable iff (init_w)
    set_q[`FLD_WRAP] |=> flag_r[`FLD_WRAP] && !$stable(prev_r))
    else $error("wrap flag not set after wrap");
  a_one_no_clear: assert property (@(posedge aclk) disable iff (init_w)
    wr_status && wdata[`FLD_WRAP] && flag_r[`FLD_WRAP]
    |=> flag_r[`FLD_WRAP]) else $error("writing one cleared wrap flag");
  a_irq_and: assert property (@(posedge aclk) disable iff (init_w)
    irq_q == (flag_r & en_r)) else $error("request not flag and enable");

endmodule : timer_chan_flags
`default_nettype wire

/* File: hdl/timer_irq_top.sv */
// five-channel timer interrupt flag block behind an AXI4-Lite slave
// assumes counter logic on aclk drives counts, general registers and
// strobes; the DMA start pulses come from the controller on aclk too
//
// Notes on behaviour
// - flag b clears by read-as-one then zero
// - compare mode: flag b on count equal
// - capture mode: flag b on capture strobe
// - flag a clears by read-as-one then zero
// - channels 0-3: DMA start clears flag a
// - compare mode: flag a on count equal
// - capture mode: flag a on capture strobe
// - one enable register per channel, five
// - enable register is F8 after reset, standby
// - upper five bits ignore writes, read ones
// - three enable bits read back last write
// - enable bit 2 gates wrap request
// - enable bit 1 gates match b request
// - enable bit 0 gates match a request
// - wrap flag on count wrap either way
// - writing one to a flag does nothing
// - status register is F8 after reset, standby
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_regs.svh"

module timer_irq_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // write data channel
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // write response channel
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // read address channel
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // read data channel
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // power state
  input  wire logic        standby,
  // counter side, channel i in slice i
  input  wire logic [79:0] timer_count,
  input  wire logic [79:0] general_reg_a,
  input  wire logic [79:0] general_reg_b,
  input  wire logic [4:0]  count_step,
  input  wire logic [4:0]  cap_mode_a,
  input  wire logic [4:0]  cap_mode_b,
  input  wire logic [4:0]  cap_a,
  input  wire logic [4:0]  cap_b,
  // dma controller started by match a, channels 0 to 3
  input  wire logic [3:0]  dma_start_a,
  // per-channel requests to the cpu
  output logic [4:0]       match_irq_a,
  output logic [4:0]       match_irq_b,
  output logic [4:0]       wrap_irq,
  // summary interrupt
  output logic             irq
);

  localparam int NCH = 5; // channel count

  // bus handshake state
  logic        awready_r;    // address slot free
  logic        wready_r;     // data slot free
  logic        aw_hold_r;    // write address held
  logic        w_hold_r;     // write data held
  logic [7:0]  aw_addr_r;    // held write address
  logic [31:0] w_data_r;     // held write data
  logic [3:0]  w_strb_r;     // held byte enables
  logic        bvalid_r;     // write answer pending
  logic [1:0]  bresp_r;      // write answer code
  logic        arready_r;    // read slot free
  logic        rvalid_r;     // read answer pending
  logic [31:0] rdata_r;      // read answer data
  logic [1:0]  rresp_r;      // read answer code
  logic        aw_hold_nxt;
  logic        w_hold_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;

  // handshake terms
  logic        aw_take;      // address accepted
  logic        w_take;       // data accepted
  logic        wr_go;        // both halves present, do the write
  logic        ar_take;      // read accepted

  // write decode on held address
  logic        wr_ch_hit;    // inside a channel window
  logic        wr_sum_hit;   // summary register
  logic        wr_mask_hit;  // mask register
  logic        wr_hit;       // any mapped word
  logic [2:0]  wr_ch;        // channel number

  // read decode on the request address
  logic        rd_ch_hit;
  logic        rd_sum_hit;
  logic        rd_mask_hit;
  logic        rd_hit;
  logic [2:0]  rd_ch;
  logic [31:0] rd_mux;       // word to return

  // per-channel strobes and views
  logic [NCH-1:0] rd_status;
  logic [NCH-1:0] wr_status;
  logic [NCH-1:0] wr_enable;
  logic [4:0]     dma_vec;   // channel 4 has no dma clear
  logic [7:0]     stat_v [NCH];
  logic [7:0]     en_v   [NCH];
  logic [7:0]     rd_chan [NCH];
  timer_irq_pkg::field3_t irq_v [NCH];
  logic [3*NCH-1:0] set_all; // every flag set pulse

  // summary events
  logic [3*NCH-1:0] seen_r, seen_nxt; // sticky events
  logic [3*NCH-1:0] mask_r, mask_nxt; // their gates
  logic             irq_r;
  logic             sum_rd;           // summary read clears it

  // request outputs gathered from the channels
  logic [NCH-1:0] irq_a_w;
  logic [NCH-1:0] irq_b_w;
  logic [NCH-1:0] irq_wrap_w;

  // handshake decode
  assign aw_take = awvalid & awready_r;
  assign w_take  = wvalid & wready_r;
  assign ar_take = arvalid & arready_r;
  // the write waits for both halves and a free answer slot
  assign wr_go   = aw_hold_r & w_hold_r & ~bvalid_r;

  assign aw_hold_nxt = aw_take | (aw_hold_r & ~wr_go);
  assign w_hold_nxt  = w_take | (w_hold_r & ~wr_go);
  assign bvalid_nxt  = wr_go | (bvalid_r & ~bready);
  assign rvalid_nxt  = ar_take | (rvalid_r & ~rready);

  // channel windows sit below the summary word, one word aligned each
  assign wr_ch       = aw_addr_r[5:3];
  assign wr_ch_hit   = (aw_addr_r < `SUMMARY_OFF) &
                       (aw_addr_r[1:0] == 2'h0);
  assign wr_sum_hit  = aw_addr_r == `SUMMARY_OFF;
  assign wr_mask_hit = aw_addr_r == `MASK_OFF;
  assign wr_hit      = wr_ch_hit | wr_sum_hit | wr_mask_hit;

  assign rd_ch       = araddr[5:3];
  assign rd_ch_hit   = (araddr < `SUMMARY_OFF) & (araddr[1:0] == 2'h0);
  assign rd_sum_hit  = araddr == `SUMMARY_OFF;
  assign rd_mask_hit = araddr == `MASK_OFF;
  assign rd_hit      = rd_ch_hit | rd_sum_hit | rd_mask_hit;

  // only the low byte lane carries the channel fields
  assign sum_rd  = ar_take & rd_sum_hit;
  assign dma_vec = {1'b0, dma_start_a};

  // one flag block per channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // strobes for this channel's two words
      assign rd_status[gi] = ar_take & rd_ch_hit &
        (rd_ch == 3'(gi)) & (araddr[2] == 1'(`STATUS_OFF >> 2));
      assign wr_status[gi] = wr_go & wr_ch_hit & w_strb_r[0] &
        (wr_ch == 3'(gi)) & (aw_addr_r[2] == 1'(`STATUS_OFF >> 2));
      assign wr_enable[gi] = wr_go & wr_ch_hit & w_strb_r[0] &
        (wr_ch == 3'(gi)) & (aw_addr_r[2] == 1'(`ENABLE_OFF >> 2));
      // this channel's word, or zero when not addressed
      assign rd_chan[gi] = (rd_ch != 3'(gi)) ? 8'h00
        : (araddr[2] ? en_v[gi] : stat_v[gi]);

      // separate enable register in every channel
      timer_chan_flags u_ch (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .standby       (standby),
        .timer_count   (timer_count[gi*16 +: 16]),
        .general_reg_a (general_reg_a[gi*16 +: 16]),
        .general_reg_b (general_reg_b[gi*16 +: 16]),
        .count_step    (count_step[gi]),
        .cap_mode_a    (cap_mode_a[gi]),
        .cap_mode_b    (cap_mode_b[gi]),
        .cap_a         (cap_a[gi]),
        .cap_b         (cap_b[gi]),
        .dma_clear_a   (dma_vec[gi]),
        .rd_status     (rd_status[gi]),
        .wr_status     (wr_status[gi]),
        .wr_enable     (wr_enable[gi]),
        .wdata         (w_data_r[2:0]),
        .status_q      (stat_v[gi]),
        .enable_q      (en_v[gi]),
        .irq_q         (irq_v[gi]),
        .set_q         (set_all[gi*3 +: 3])
      );

      // fan the three requests out by kind
      assign irq_a_w[gi]    = irq_v[gi][`FLD_A];
      assign irq_b_w[gi]    = irq_v[gi][`FLD_B];
      assign irq_wrap_w[gi] = irq_v[gi][`FLD_WRAP];
    end
  endgenerate

  // read word selection; unaddressed channels contribute zero
  assign rd_mux = rd_ch_hit   ? {24'h0, rd_chan[0] | rd_chan[1] |
                                 rd_chan[2] | rd_chan[3] | rd_chan[4]}
                : rd_sum_hit  ? {17'h0, seen_r}
                : rd_mask_hit ? {17'h0, mask_r}
                : 32'h0;

  // summary: a new event wins over the read that clears
  assign seen_nxt = set_all | (seen_r & ~{3*NCH{sum_rd}});
  assign mask_nxt = (wr_go & wr_mask_hit) ?
    {w_strb_r[1] ? w_data_r[14:8] : mask_r[14:8],
     w_strb_r[0] ? w_data_r[7:0]  : mask_r[7:0]} : mask_r;

  // write side handshake; slots reopen only after the answer leaves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
    end
  end

  // held write payload and its answer code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bresp_r   <= 2'h0;
    end else begin
      aw_addr_r <= aw_take ? awaddr : aw_addr_r;
      w_data_r  <= w_take ? wdata : w_data_r;
      w_strb_r  <= w_take ? wstrb : w_strb_r;
      // unmapped words answer with an error and change nothing
      if (wr_go) begin
        bresp_r <= wr_hit ? timer_irq_pkg::RESP_OKAY
                          : timer_irq_pkg::RESP_SLVERR;
      end
    end
  end

  // read side: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? timer_irq_pkg::RESP_OKAY
                          : timer_irq_pkg::RESP_SLVERR;
      end
    end
  end

  // summary events, mask and the one level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= 15'h0000;
      mask_r <= 15'h0000;
      irq_r  <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      mask_r <= mask_nxt;
      irq_r  <= |(seen_nxt & mask_nxt);
    end
  end

  // ports straight from flip-flops
  assign awready     = awready_r;
  assign wready      = wready_r;
  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign arready     = arready_r;
  assign rvalid      = rvalid_r;
  assign rdata       = rdata_r;
  assign rresp       = rresp_r;
  assign irq         = irq_r;
  // channel requests already registered inside each channel
  assign match_irq_a = irq_a_w;
  assign match_irq_b = irq_b_w;
  assign wrap_irq    = irq_wrap_w;

  // a status read returns the reserved ones above the flags
  a_rd_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_ch_hit |=> rdata_r[7:3] == `RSVD_ONES)
    else $error("reserved bits did not read as ones");
  // enable written then read back unchanged, channel 0
  sequence s_en_wr0;
    wr_enable[0] && !standby;
  endsequence
  a_en_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    s_en_wr0 |=> en_v[0][2:0] == $past(w_data_r[2:0]))
    else $error("enable bits lost the written value");
  // wrap request of channel 1 only with its wrap flag and enable set
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    wrap_irq[1] |-> stat_v[1][`FLD_WRAP] && en_v[1][`FLD_WRAP])
    else $error("wrap request without flag and enable");
  // write answer comes one cycle after both halves meet
  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid_r && !awready_r && !wready_r)
    else $error("write answer late");

endmodule : timer_irq_top
`default_nettype wire

/* File: bench/count_side_model.sv */
// far side model: counter values, capture pulses and dma starts
// assumes the bench calls its tasks one at a time from one process
`timescale 1ns/1ps
`default_nettype none

module count_side_model (
  // clock
  input  wire logic   aclk,
  // counter side, channel i in slice i
  output logic [79:0] timer_count,
  output logic [79:0] general_reg_a,
  output logic [79:0] general_reg_b,
  output logic [4:0]  count_step,
  output logic [4:0]  cap_mode_a,
  output logic [4:0]  cap_mode_b,
  output logic [4:0]  cap_a,
  output logic [4:0]  cap_b,
  // dma starts by match a, channels 0 to 3
  output logic [3:0]  dma_start_a
);
  // idle in compare mode
  initial begin
    {timer_count, general_reg_a, general_reg_b} = '0;
    {count_step, cap_mode_a, cap_mode_b, cap_a, cap_b, dma_start_a} = '0;
  end
  // pulses last one cycle only
  task automatic drop();
    @(posedge aclk);
    {count_step, cap_a, cap_b, dma_start_a} <= '0;
  endtask : drop
  // counter steps to v
  task automatic step(input int c, input logic [15:0] v);
    @(posedge aclk);
    timer_count[16*c+:16] <= v;
    count_step[c]         <= 1'b1;
    drop();
  endtask : step
  // event on register b or a: capture pulse, else compare step at v
  task automatic hit(input int c, input bit b, input bit cap,
                     input logic [15:0] v);
    @(posedge aclk);
    if (b) begin
      cap_mode_b[c]           <= cap;
      general_reg_b[16*c+:16] <= v; // capture copies count
      cap_b[c]                <= cap;
    end else begin
      cap_mode_a[c]           <= cap;
      general_reg_a[16*c+:16] <= v; // capture copies count
      cap_a[c]                <= cap;
    end
    timer_count[16*c+:16] <= v;
    count_step[c]         <= !cap;
    drop();
  endtask : hit
  // dma started on the channels set in m
  task automatic dma(input logic [3:0] m);
    @(posedge aclk);
    dma_start_a <= m;
    drop();
  endtask : dma
endmodule : count_side_model
`default_nettype wire

/* File: bench/timer_irq_top_tb_top.sv */
// self-checking bench of the timer interrupt flag block
// assumes the far side model and an AXI4-Lite master on aclk
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_regs.svh"

module timer_irq_top_tb_top;
  logic        aclk, aresetn, standby;        // clock, reset, power
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;                // byte addresses
  logic [31:0] wdata;
  wire  logic  awready, wready, bvalid, arready, rvalid, irq;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  wire  logic [79:0] timer_count, general_reg_a, general_reg_b;
  wire  logic [4:0]  count_step, cap_mode_a, cap_mode_b, cap_a, cap_b;
  wire  logic [4:0]  match_irq_a, match_irq_b, wrap_irq;
  wire  logic [3:0]  dma_start_a;
  logic [33:0] exp_q[$];                      // notes {resp, data}
  logic [2:0]  flg[5], en[5];                 // flag and enable model
  logic [14:0] sum;                           // summary model
  int          n_fail, num_checks;
  timer_irq_top uut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .standby, .timer_count,
    .general_reg_a, .general_reg_b, .count_step, .cap_mode_a,
    .cap_mode_b, .cap_a, .cap_b, .dma_start_a, .match_irq_a,
    .match_irq_b, .wrap_irq, .irq);
  count_side_model fm (
    .aclk, .timer_count, .general_reg_a, .general_reg_b, .count_step,
    .cap_mode_a, .cap_mode_b, .cap_a, .cap_b, .dma_start_a);
  // one compare, mismatch reported at once
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // read answers taken off the note queue in order
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  end
  // status or enable word as read: reserved ones above the fields
  function automatic logic [33:0] sw(input logic [2:0] f);
    return {26'h0, 5'h1F, f};
  endfunction : sw
  function automatic logic [7:0] ra(input int c, input bit e);
    return 8'(c * `CH_STRIDE) + (e ? `ENABLE_OFF : `STATUS_OFF);
  endfunction : ra
  // write: address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata  <= d;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk(34'(bresp), 34'(r));
  endtask : wr
  // read: expectation noted first, checked by the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  // requests must equal flag and enable, channel by channel
  task automatic chk_irq();
    logic [14:0] e;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 15; i++) e[i] = flg[i%5][i/5] & en[i%5][i/5];
    chk(34'({wrap_irq, match_irq_b, match_irq_a}), 34'(e));
  endtask : chk_irq
  // after reset or standby every channel word reads back idle
  task automatic idle_check();
    for (int i = 0; i < 5; i++) begin
      {flg[i], en[i]} = '0;
      rd(ra(i, 0), sw(3'h0));
      rd(ra(i, 1), sw(3'h0));
    end
    chk_irq();
  endtask : idle_check
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // hang guard, far above the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end
  initial begin
    logic [15:0] v;
    int          c;
    void'($urandom(32'hB844F796));
    {aresetn, standby, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, sum, n_fail, num_checks} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    idle_check();
    // random enables, reserved bits written with noise
    for (int i = 0; i < 5; i++) begin
      en[i] = 3'($urandom);
      wr(ra(i, 1), ($urandom & 32'hFFFF_FFF8) | 32'(en[i]), 2'b00);
      rd(ra(i, 1), sw(en[i]));
    end
    rd(8'h30, {timer_irq_pkg::RESP_SLVERR, 32'h0});
    wr(8'h30, 32'hFF, timer_irq_pkg::RESP_SLVERR);
    // every event kind on every channel, modes alternating
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom_range(1, 32'hFFFD));
      fm.hit(i, 1'b0, i[0], v);
      fm.hit(i, 1'b1, !i[0], v + 16'h0001);
      fm.step(i, 16'hFFFF);
      fm.step(i, 16'h0000);
      flg[i] = 3'h7;
      sum |= 15'(7) << (3 * i);
      chk_irq();
      rd(ra(i, 0), sw(flg[i]));
    end
    // ones ignored; a zero clears only after a read of one
    c = $urandom_range(0, 4);
    wr(ra(c, 0), 32'hFF, 2'b00);
    rd(ra(c, 0), sw(3'h7));
    wr(ra(c, 0), 32'hFD, 2'b00);
    wr(ra(c, 0), 32'h00, 2'b00);
    flg[c] = 3'h5;
    rd(ra(c, 0), sw(flg[c]));
    wr(ra(c, 0), 32'h00, 2'b00);
    flg[c] = 3'h0;
    chk_irq();
    fm.step(c, 16'hFFFF);
    flg[c] = 3'h4;
    rd(ra(c, 0), sw(flg[c]));
    // dma start reaches flag a of channels 0 to 3 only
    fm.dma(4'hF);
    for (int i = 0; i < 4; i++) flg[i][0] = 1'b0;
    chk_irq();
    rd(ra(4, 0), sw(flg[4]));
    // summary line: masked, raised, cleared by its read
    wr(`MASK_OFF, 32'h0, 2'b00);
    repeat (3) @(posedge aclk);
    chk(34'(irq), 34'h0);
    wr(`MASK_OFF, 32'h7FFF, 2'b00);
    repeat (3) @(posedge aclk);
    chk(34'(irq), 34'h1);
    rd(`SUMMARY_OFF, {19'h0, sum});
    repeat (3) @(posedge aclk);
    chk(34'(irq), 34'h0);
    // standby acts like reset on both registers
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
    idle_check();
    conclude();
  end
endmodule : timer_irq_top_tb_top
`default_nettype wire
